// file: design/touch_probe_defines.vh
// constants for the touch probe edge capture unit
// assumes inclusion by bare name from the design files
`ifndef TOUCH_PROBE_DEFINES_VH
`define TOUCH_PROBE_DEFINES_VH

// register indices, byte address is index times four
`define IDX_FUNC_CTL    16'h60B8
`define IDX_STATUS      16'h60B9
`define IDX_P1_RISE_POS 16'h60BA
`define IDX_P1_FALL_POS 16'h60BB
`define IDX_P2_RISE_POS 16'h60BC
`define IDX_P2_FALL_POS 16'h60BD
`define IDX_P1_RISE_CNT 16'h60D5
`define IDX_P1_FALL_CNT 16'h60D6
`define IDX_P2_RISE_CNT 16'h60D7
`define IDX_P2_FALL_CNT 16'h60D8

// bit positions within one channel's byte of control and status
`define CH_STRIDE   8
`define CTL_ENABLE  0
`define CTL_CONT    1
`define CTL_ZSRC    2
`define CTL_RISE_EN 4
`define CTL_FALL_EN 5
`define STS_ENABLED 0
`define STS_RSTORED 1
`define STS_FSTORED 2
`define STS_RTOGGLE 6
`define STS_FTOGGLE 7

// reset values and bus answers
`define FUNC_CTL_RST 16'h0000
// reserved and unused control bits read back as zero
`define CTL_BYTE_MASK 8'h37
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

// file: design/edge_sync.v
// two-stage synchroniser with rising and falling edge pulses
// assumes sig_in is asynchronous to clk; pulses last one cycle
`include "touch_probe_defines.vh"

module edge_sync (
  // clock and reset
  input  wire clk,
  input  wire rst,
  // raw input
  input  wire sig_in,
  // edge pulses
  output reg  rise_q,
  output reg  fall_q
);

  reg meta_q;
  reg sync_q;
  reg last_q;

  // only sync_q reads meta_q, so metastability stays in stage one
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      meta_q <= sig_in;
      sync_q <= meta_q;
      last_q <= sync_q;
      rise_q <= sync_q & ~last_q; // one pulse per physical edge
      fall_q <= ~sync_q & last_q;
    end
  end

endmodule // edge_sync

// file: design/touch_probe_edge_capture.v
// touch probe unit: two channels, edge counters, position latches
// assumes an AXI4-Lite master on clk and a drive position on clk
//
// Function
// - four counters, rise and fall per probe
// - counters valid only while channel enabled
// - disabled channel holds both counters at zero
// - counting ignores the edge capture enables
// - continuous: 16-bit counters wrap to zero
// - mode bit: zero single shot, one continuous
// - source bit: zero probe pin, one zero pulse
// - zero pulse source ignores falling edge enable
// - zero pulse captures go to rising register
// - enabled edge latches actual drive position, single shot only the first
// - stored flags sticky until disable or unenable
// - toggle flags flip per edge, cleared unenabled
// - disabling channel clears all its status
`include "touch_probe_defines.vh"

module touch_probe_edge_capture #(
  parameter AW    = 20,
  parameter POS_W = 32,
  parameter CNT_W = 16
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  // probe pins and encoder zero pulse
  input  wire             probe_one_input,
  input  wire             probe_two_input,
  input  wire             zero_pulse,
  // actual drive position
  input  wire [POS_W-1:0] actual_position,
  // axi4-lite write address
  input  wire [AW-1:0]    s_axi_awaddr,
  input  wire [2:0]       s_axi_awprot,
  input  wire             s_axi_awvalid,
  output reg              s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output reg              s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  // axi4-lite read address
  input  wire [AW-1:0]    s_axi_araddr,
  input  wire [2:0]       s_axi_arprot,
  input  wire             s_axi_arvalid,
  output reg              s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready
);

  // address decode shared by read and write paths
  function hit;
    input [AW-1:0] addr;
    input [15:0]   idx;
    begin
      hit = (addr[17:2] == idx);
    end
  endfunction

  function mapped;
    input [AW-1:0] addr;
    begin
      mapped = hit(addr, `IDX_FUNC_CTL)    | hit(addr, `IDX_STATUS)      |
               hit(addr, `IDX_P1_RISE_POS) | hit(addr, `IDX_P1_FALL_POS) |
               hit(addr, `IDX_P2_RISE_POS) | hit(addr, `IDX_P2_FALL_POS) |
               hit(addr, `IDX_P1_RISE_CNT) | hit(addr, `IDX_P1_FALL_CNT) |
               hit(addr, `IDX_P2_RISE_CNT) | hit(addr, `IDX_P2_FALL_CNT);
    end
  endfunction

  reg  [15:0]       ctl_q;
  reg  [AW-1:0]     awaddr_q;
  reg               aw_full_q;
  reg  [31:0]       wdata_q;
  reg  [3:0]        wstrb_q;
  reg               w_full_q;
  reg  [31:0]       rdata_d;
  wire [15:0]       status;
  wire [2:0]        raw_in;
  wire [2:0]        rise_p;
  wire [2:0]        fall_p;

  reg  [CNT_W-1:0]  rcnt_q  [0:1];
  reg  [CNT_W-1:0]  fcnt_q  [0:1];
  reg  [POS_W-1:0]  rpos_q  [0:1];
  reg  [POS_W-1:0]  fpos_q  [0:1];
  reg  [1:0]        rstored_q;
  reg  [1:0]        fstored_q;
  reg  [1:0]        rtgl_q;
  reg  [1:0]        ftgl_q;

  // inputs brought into clk: probe one, probe two, zero pulse
  assign raw_in = {zero_pulse, probe_two_input, probe_one_input};

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
      edge_sync u_sync (
        .clk    (clk),
        .rst    (rst),
        .sig_in (raw_in[g]),
        .rise_q (rise_p[g]),
        .fall_q (fall_p[g])
      );
    end
  endgenerate

  // per channel capture, flags and counters
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ch
      wire [7:0] c      = ctl_q[`CH_STRIDE*g +: 8];
      wire       en     = c[`CTL_ENABLE];
      wire       zsrc   = c[`CTL_ZSRC];
      wire       ren    = c[`CTL_RISE_EN];
      wire       fen    = c[`CTL_FALL_EN] & ~zsrc;
      wire       t_rise = zsrc ? rise_p[2] : rise_p[g];
      wire       t_fall = zsrc ? 1'b0 : fall_p[g];
      // toggles follow every enabled trigger edge, captured or not
      wire       r_edge = en & ren & t_rise;
      wire       f_edge = en & fen & t_fall;
      // single shot allows only the first event of either edge
      wire       armed  = c[`CTL_CONT] | ~(rstored_q[g] | fstored_q[g]);
      wire       rcap   = en & ren & t_rise & armed;
      wire       fcap   = en & fen & t_fall & armed;

      assign status[`CH_STRIDE*g +: 8] = {ftgl_q[g], rtgl_q[g], 3'h0, fstored_q[g],
                                          rstored_q[g], en};

      // position latches keep their last value across disable
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          rpos_q[g] <= {POS_W{1'b0}};
          fpos_q[g] <= {POS_W{1'b0}};
        end else begin
          if (rcap)
            rpos_q[g] <= actual_position;
          if (fcap)
            fpos_q[g] <= actual_position;
        end
      end

      // set wins over clear for stored flags; a low edge enable clears the toggle flags
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          rcnt_q[g]    <= {CNT_W{1'b0}};
          fcnt_q[g]    <= {CNT_W{1'b0}};
          rstored_q[g] <= 1'b0;
          fstored_q[g] <= 1'b0;
          rtgl_q[g]    <= 1'b0;
          ftgl_q[g]    <= 1'b0;
        end else if (!en) begin
          rcnt_q[g]    <= {CNT_W{1'b0}};
          fcnt_q[g]    <= {CNT_W{1'b0}};
          rstored_q[g] <= 1'b0;
          fstored_q[g] <= 1'b0;
          rtgl_q[g]    <= 1'b0;
          ftgl_q[g]    <= 1'b0;
        end else begin
          // pin edges counted regardless of edge enables, wrap free
          if (rise_p[g])
            rcnt_q[g] <= rcnt_q[g] + 1'b1;
          if (fall_p[g])
            fcnt_q[g] <= fcnt_q[g] + 1'b1;
          rstored_q[g] <= rcap | (rstored_q[g] & ren);
          fstored_q[g] <= fcap | (fstored_q[g] & fen);
          rtgl_q[g]    <= ren & (rtgl_q[g] ^ r_edge);
          ftgl_q[g]    <= fen & (ftgl_q[g] ^ f_edge);
        end
      end
    end
  endgenerate

  // write channel: address and data taken in either order
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      awaddr_q      <= {AW{1'b0}};
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      ctl_q         <= `FUNC_CTL_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= s_axi_awaddr;
        aw_full_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        w_full_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_full_q && w_full_q && !s_axi_bvalid) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
        // only the function word is writable; others ignore writes
        if (hit(awaddr_q, `IDX_FUNC_CTL)) begin
          if (wstrb_q[0])
            ctl_q[7:0] <= wdata_q[7:0] & `CTL_BYTE_MASK;
          if (wstrb_q[1])
            ctl_q[15:8] <= wdata_q[15:8] & `CTL_BYTE_MASK;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read data selection
  always @* begin
    rdata_d = 32'h00000000;
    if (hit(s_axi_araddr, `IDX_FUNC_CTL))
      rdata_d = {16'h0000, ctl_q};
    else if (hit(s_axi_araddr, `IDX_STATUS))
      rdata_d = {16'h0000, status};
    else if (hit(s_axi_araddr, `IDX_P1_RISE_POS))
      rdata_d = rpos_q[0];
    else if (hit(s_axi_araddr, `IDX_P1_FALL_POS))
      rdata_d = fpos_q[0];
    else if (hit(s_axi_araddr, `IDX_P2_RISE_POS))
      rdata_d = rpos_q[1];
    else if (hit(s_axi_araddr, `IDX_P2_FALL_POS))
      rdata_d = fpos_q[1];
    else if (hit(s_axi_araddr, `IDX_P1_RISE_CNT))
      rdata_d = {16'h0000, rcnt_q[0]};
    else if (hit(s_axi_araddr, `IDX_P1_FALL_CNT))
      rdata_d = {16'h0000, fcnt_q[0]};
    else if (hit(s_axi_araddr, `IDX_P2_RISE_CNT))
      rdata_d = {16'h0000, rcnt_q[1]};
    else if (hit(s_axi_araddr, `IDX_P2_FALL_CNT))
      rdata_d = {16'h0000, fcnt_q[1]};
  end

  // read channel: one read in flight, answer the cycle after address
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdata_d;
        s_axi_rresp   <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // touch_probe_edge_capture

// file: bench/probe_source_model.sv
// far side stand-in: probe switches and encoder zero pulse
// assumes pulses of four or more control clocks
module probe_source_model (
  // probe pins and zero pulse
  output wire probe_one_input,
  output wire probe_two_input,
  output wire zero_pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] lvl_q = 3'h0;
  assign {zero_pulse, probe_two_input, probe_one_input} = lvl_q;
  // odd delays keep edges off the clock grid
  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      #17.3 lvl_q[ch] = 1'b1;
      #17.3 lvl_q[ch] = 1'b0;
    end
    #30;
  endtask
endmodule // probe_source_model

// file: bench/touch_probe_checker.sv
// bus handshake checks on the probe unit's axi4-lite ports
// assumes bind onto touch_probe_edge_capture
`include "touch_probe_defines.vh"
module touch_probe_checker (
  // clock and reset
  input wire        clk,
  input wire        rst,
  // write side
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  // read side
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  ready_back_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write side not ready again");
  err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read with data");
endmodule // touch_probe_checker

bind touch_probe_edge_capture touch_probe_checker chk_u (.clk, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// file: bench/testbench.sv
// top bench: registers over axi4-lite, probe edges from the model
// assumes design/ on the include path
`include "touch_probe_defines.vh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; $display("[ERR] %0t %h %h", $time, a, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 0;
  logic        rst = 1;
  logic [31:0] pos = 0;
  logic [19:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire  [31:0] s_axi_rdata;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         probe_one_input, probe_two_input, zero_pulse;
  int          err_total = 0, compares = 0, cyc = 0;

  touch_probe_edge_capture dut_u (.clk, .rst, .probe_one_input, .probe_two_input, .zero_pulse,
    .actual_position(pos), .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  probe_source_model src_u (.probe_one_input, .probe_two_input, .zero_pulse);

  always #2 clk = ~clk;
  // ceiling well above the whole run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end

  // ready seen at negedge is what the next rising edge samples
  task automatic wr(input [15:0] i, input [31:0] d, input [1:0] er = `RESP_OKAY);
    bit a, w, b;
    logic [1:0] r;
    @(posedge clk);
    s_axi_awaddr <= {2'h0, i, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (int n = 0; n < 40 && !b; n++) begin
      @(negedge clk);
      a = s_axi_awready & s_axi_awvalid;
      w = s_axi_wready & s_axi_wvalid;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (a) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0;
    `CHK(b, 1'b1)
    `CHK(r, er)
  endtask

  task automatic rd(input [15:0] i, input [31:0] e, input [1:0] er = `RESP_OKAY, input [31:0] m = 32'hFFFFFFFF);
    bit a, b;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    s_axi_araddr <= {2'h0, i, 2'h0};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (int n = 0; n < 40 && !b; n++) begin
      @(negedge clk);
      a = s_axi_arready & s_axi_arvalid;
      b = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (a) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
    `CHK(b, 1'b1)
    `CHK(r, er)
    `CHK(d & m, e)
  endtask

  task automatic t_regs();
    rd(`IDX_FUNC_CTL, `FUNC_CTL_RST);
    wr(`IDX_FUNC_CTL, 32'hFFFF);
    rd(`IDX_FUNC_CTL, 32'h3737);
    wr(16'h6000, 32'h1, `RESP_SLVERR);
    rd(16'h6000, 32'h0, `RESP_SLVERR);
    wr(`IDX_P1_RISE_CNT, 32'h5);
    rd(`IDX_P1_RISE_CNT, 32'h0);
    wr(`IDX_FUNC_CTL, 32'h0);
  endtask

  // only ch1 on, no edge enables
  task automatic t_count();
    wr(`IDX_FUNC_CTL, 32'h1);
    src_u.pulse(0, 3);
    src_u.pulse(2, 2);
    src_u.pulse(1, 2);
    rd(`IDX_P1_RISE_CNT, 32'h3);
    rd(`IDX_P1_FALL_CNT, 32'h3);
    rd(`IDX_P2_RISE_CNT, 32'h0);
    rd(`IDX_STATUS, 32'h1);
    wr(`IDX_FUNC_CTL, 32'h0);
    rd(`IDX_P1_RISE_CNT, 32'h0);
    rd(`IDX_STATUS, 32'h0);
  endtask

  task automatic t_cont();
    wr(`IDX_FUNC_CTL, 32'h13);
    pos <= 32'hA5A50001;
    src_u.pulse(0, 1);
    rd(`IDX_P1_RISE_POS, 32'hA5A50001);
    rd(`IDX_STATUS, 32'h43);
    pos <= 32'h00007FFF;
    src_u.pulse(0, 1);
    rd(`IDX_P1_RISE_POS, 32'h00007FFF);
    rd(`IDX_STATUS, 32'h03);
    rd(`IDX_P1_FALL_POS, 32'h0);
    wr(`IDX_FUNC_CTL, 32'h03);
    rd(`IDX_STATUS, 32'h01);
    wr(`IDX_FUNC_CTL, 32'h0);
  endtask

  // ch2 single shot, both edges enabled
  task automatic t_single();
    wr(`IDX_FUNC_CTL, 32'h3100);
    pos <= 32'h00001234;
    src_u.pulse(1, 1);
    rd(`IDX_P2_RISE_POS, 32'h00001234);
    pos <= 32'h00005678;
    src_u.pulse(1, 2);
    rd(`IDX_P2_RISE_POS, 32'h00001234);
    rd(`IDX_P2_FALL_POS, 32'h0);
    rd(`IDX_P2_RISE_CNT, 32'h1, `RESP_OKAY, 32'h1);
    rd(`IDX_STATUS, 32'hC300);
    wr(`IDX_FUNC_CTL, 32'h0100);
    rd(`IDX_STATUS, 32'h0100);
    wr(`IDX_FUNC_CTL, 32'h0);
  endtask

  // zero pulse source, fall enable set but ignored
  task automatic t_zero();
    wr(`IDX_FUNC_CTL, 32'h37);
    pos <= 32'h0BAD0042;
    src_u.pulse(2, 2);
    rd(`IDX_P1_RISE_POS, 32'h0BAD0042);
    rd(`IDX_P1_FALL_POS, 32'h0);
    rd(`IDX_STATUS, 32'h03);
    src_u.pulse(0, 1);
    rd(`IDX_P1_RISE_CNT, 32'h1);
    rd(`IDX_STATUS, 32'h03);
    wr(`IDX_FUNC_CTL, 32'h0);
  endtask

  task automatic close_out();
    $display("err_total %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    t_regs();
    t_count();
    t_cont();
    t_single();
    t_zero();
    close_out();
  end
endmodule // testbench
